// ===== rtl/timer_counter_cfg.svh
// Offsets, field positions, reset values and counts of the timer
`ifndef TIMER_COUNTER_CFG_SVH
`define TIMER_COUNTER_CFG_SVH

// Register indices on the plain register port
`define TC_OFS_LOW    3'h0
`define TC_OFS_HIGH   3'h1
`define TC_OFS_CTRL   3'h2
`define TC_OFS_FLAG   3'h3
`define TC_OFS_ENABLE 3'h4

// Control register field positions
`define TC_RUN_BIT    0
`define TC_SRC_BIT    1
`define TC_NSYNC_BIT  2
`define TC_OSC_BIT    3
`define TC_DIV_LSB    4
`define TC_DIV_MSB    5
`define TC_NONE_BIT   6
`define TC_WIDE_BIT   7

// Writable bits of the control register
`define TC_CTRL_MASK  8'hBF
// Control value after power-on reset
`define TC_CTRL_RST   8'h00
// Flag and enable bit inside their registers
`define TC_FLAG_BIT   0

// Compare mode code that raises the special event trigger
`define TC_SPECIAL_EVT 4'hB
// Core clocks per instruction cycle, minus one
`define TC_PHASE_LAST 2'h3
// Count value just before the wrap
`define TC_COUNT_TOP  16'hFFFF

`endif

// ===== rtl/timer_counter_pkg.sv
// Types shared by the timer/counter block
`default_nettype none

package timer_counter_pkg;

	// One register access from software
	typedef struct packed {
		logic [2:0] addr;  // Register index
		logic [7:0] wdata; // Write data
		logic       wr;    // Write strobe
		logic       rd;    // Read strobe
	} reg_bus_t;

	// Whole state of the timer block
	typedef struct packed {
		logic [15:0] count;  // Live counter
		logic [7:0]  hbuf;   // High byte buffer
		logic [2:0]  pre;    // Prescaler count
		logic [1:0]  phase;  // Instruction phase
		logic [7:0]  ctrl;   // Control register
		logic        flag;   // Overflow flag
		logic        irq_en; // Overflow enable
		logic [1:0]  s1;     // Pin sync stage one
		logic [1:0]  s2;     // Pin sync stage two
		logic        prev;   // Last source level
		logic        pend;   // Edge waiting for tick
		logic [7:0]  rdata;  // Read data
		logic        adc_go; // Conversion start
	} tc_state_t;

endpackage : timer_counter_pkg

`default_nettype wire

// ===== rtl/timer_counter.sv
// Sixteen-bit timer/counter with prescaler and buffered access
//
// Overview of operation
// [R1] Counts only while run-enable bit is set
// [R2] Prescale field divides by 1, 2, 4, 8
// [R3] Source bit picks external edge or instruction clock
// [R4] Sync bit chooses synchronized external counting
// [R5] Oscillator enable makes oscillator the source
// [R6] Oscillator on: pins inputs, port reads zero
// [R7] Bit six reads back as zero
// [R8] One step per instruction cycle or edge
// [R9] Count wraps from FFFFh to 0000h
// [R10] Wrap sets sticky flag; enable gates request
// [R11] Special event trigger resets counter, starts conversion
// [R12] Trigger reset never sets the overflow flag
// [R13] Trigger reset only sure when synchronized
// [R14] Counter write beats a coincident trigger
// [R15] Wide mode maps high address to buffer
// [R16] Low byte read copies high byte to buffer
// [R17] Low byte write loads buffer into high
// [R18] Only low byte writes clear the prescaler (the code also clears it on a special event trigger)
// [R19] Reset clears control; counter value undefined
// [R20] Narrow mode reaches live high byte directly
//
// Local design decisions: strobed register access and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "timer_counter_cfg.svh"

module timer_counter (
	// Clock and reset
	input  wire logic                        clk,
	input  wire logic                        sys_rst,
	// Register port
	input  wire timer_counter_pkg::reg_bus_t bus,
	output logic [7:0]                       rd_data,
	// Count inputs from pins
	input  wire logic                        ext_count_pin,
	input  wire logic                        osc_in_pin,
	// Port direction and pin view
	input  wire logic [1:0]                  port_direction_reg,
	output logic [1:0]                       pin_oe,
	output logic [1:0]                       port_read,
	// Compare unit and converter
	input  wire logic [3:0]                  compare_mode_field,
	input  wire logic                        compare_match,
	input  wire logic                        adc_enable,
	output logic                             adc_start,
	// Interrupt request
	output logic                             irq_req
);

	////////////////////////////////////////////////////////////////
	// State and decoded controls

	timer_counter_pkg::tc_state_t st_r;   // Registered state
	timer_counter_pkg::tc_state_t st_nxt; // Next state

	logic       run;      // Run enable
	logic       ext_src;  // External source chosen
	logic       no_sync;  // Unsynchronized counting
	logic       osc_on;   // Oscillator enabled
	logic       wide;     // Buffered access mode
	logic [1:0] div_sel;  // Prescale select
	logic [2:0] div_last; // Last prescaler value
	logic       tick;     // Instruction cycle tick
	logic       src_lvl;  // Selected source level
	logic       rise;     // Rising edge of source
	logic       ev;       // Count clock event
	logic       step;     // Counter advances
	logic       trig;     // Special event trigger
	logic       wr_low;   // Write to low byte
	logic       wr_high;  // Write to high byte
	logic       rd_low;   // Read of low byte

	assign run     = st_r.ctrl[`TC_RUN_BIT];
	assign ext_src = st_r.ctrl[`TC_SRC_BIT];
	assign no_sync = st_r.ctrl[`TC_NSYNC_BIT];
	assign osc_on  = st_r.ctrl[`TC_OSC_BIT];
	assign wide    = st_r.ctrl[`TC_WIDE_BIT];
	assign div_sel = st_r.ctrl[`TC_DIV_MSB:`TC_DIV_LSB];

	// Strobe decode
	assign wr_low  = bus.wr && (bus.addr == `TC_OFS_LOW);
	assign wr_high = bus.wr && (bus.addr == `TC_OFS_HIGH);
	assign rd_low  = bus.rd && (bus.addr == `TC_OFS_LOW);

	////////////////////////////////////////////////////////////////
	// Count clock selection

	// One tick per four core clocks
	assign tick = (st_r.phase == `TC_PHASE_LAST); // see [R3]

	// Oscillator output replaces the pin
	assign src_lvl = osc_on ? st_r.s2[1] : st_r.s2[0]; // see [R5]

	// Edge seen on the synchronized level
	assign rise = src_lvl && !st_r.prev;

	// Pick the event that feeds the prescaler
	always_comb begin
		if (!ext_src) begin
			// Sync bit has no say here
			ev = tick; // see [R3] see [R4] see [R8]
		end else if (no_sync) begin
			// Edge counted as soon as seen
			ev = rise; // see [R4] see [R8]
		end else begin
			// Edge held until the tick
			ev = tick && (st_r.pend || rise); // see [R4]
		end
	end

	// Divider end value from the field
	always_comb begin
		case (div_sel)
			2'h0:    div_last = 3'h0;
			2'h1:    div_last = 3'h1;
			2'h2:    div_last = 3'h3;
			2'h3:    div_last = 3'h7;
			default: div_last = 3'h0;
		endcase
	end

	// Counter moves on the last prescaler event; a count left over
	// from a larger divide steps at once instead of wrapping round
	assign step = run && ev && (st_r.pre >= div_last); // see [R1] see [R2]

	// Trigger from the compare unit; taken alike with sync on or off
	assign trig = compare_match &&
		(compare_mode_field == `TC_SPECIAL_EVT); // see [R11] see [R13]

	////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		st_nxt = st_r;

		// Two flip-flops per pin before use
		st_nxt.s1    = {osc_in_pin, ext_count_pin};
		st_nxt.s2    = st_r.s1;
		st_nxt.prev  = src_lvl;
		st_nxt.phase = st_r.phase + 2'h1;
		st_nxt.adc_go = 1'b0;

		// Pending edge for synchronized counting
		if (tick) begin
			st_nxt.pend = 1'b0;
		end else if (rise) begin
			st_nxt.pend = 1'b1;
		end

		// Prescaler runs only while counting
		if (run && ev) begin
			if (st_r.pre >= div_last) begin
				st_nxt.pre = 3'h0; // see [R2]
			end else begin
				st_nxt.pre = st_r.pre + 3'h1; // see [R2]
			end
		end

		// Counter advance and wrap
		if (step) begin
			st_nxt.count = st_r.count + 16'h0001; // see [R9]
			if (st_r.count == `TC_COUNT_TOP) begin
				st_nxt.flag = 1'b1; // see [R10]
			end
		end

		// Trigger clears count, flag untouched
		if (trig) begin
			st_nxt.count = 16'h0000; // see [R11] see [R12]
			st_nxt.pre   = 3'h0;
			st_nxt.adc_go = adc_enable; // see [R11]
		end

		// Register writes; these beat trigger
		if (bus.wr) begin
			case (bus.addr)
				`TC_OFS_LOW: begin
					if (wide) begin
						// Both bytes at once
						st_nxt.count = {st_r.hbuf, bus.wdata}; // see [R17]
					end else begin
						st_nxt.count[7:0] = bus.wdata; // see [R14]
						// High byte keeps any step unless a trigger coincides
						if (!trig) begin
							st_nxt.count[15:8] = step ?
								st_nxt.count[15:8] : st_r.count[15:8];
						end else begin
							st_nxt.count[15:8] = st_r.count[15:8];
						end
					end
					st_nxt.pre = 3'h0; // see [R18]
				end
				`TC_OFS_HIGH: begin
					if (wide) begin
						// Buffer only in wide mode
						st_nxt.hbuf = bus.wdata; // see [R15]
					end else begin
						st_nxt.count[15:8] = bus.wdata; // see [R20]
						if (trig) begin
							st_nxt.count[7:0] = st_r.count[7:0]; // see [R14]
						end
					end
					// Prescaler left alone here, see [R18]
					if (trig) begin
						st_nxt.pre = st_r.pre;
					end
				end
				`TC_OFS_CTRL: begin
					st_nxt.ctrl = bus.wdata & `TC_CTRL_MASK; // see [R7]
				end
				`TC_OFS_FLAG: begin
					// Hardware set wins over clear, see [R10]
					if (bus.wdata[`TC_FLAG_BIT]) begin
						st_nxt.flag = 1'b1;
					end else begin
						st_nxt.flag = step &&
							(st_r.count == `TC_COUNT_TOP);
					end
				end
				`TC_OFS_ENABLE: begin
					st_nxt.irq_en = bus.wdata[`TC_FLAG_BIT];
				end
				default: begin
					// Unmapped write ignored
				end
			endcase
		end

		// Read data, one cycle after the strobe
		st_nxt.rdata = 8'h00;
		if (bus.rd) begin
			case (bus.addr)
				`TC_OFS_LOW: begin
					st_nxt.rdata = st_r.count[7:0];
					if (wide) begin
						st_nxt.hbuf = st_r.count[15:8]; // see [R16]
					end
				end
				`TC_OFS_HIGH: begin
					// Buffer or live byte by mode
					st_nxt.rdata = wide ? st_r.hbuf :
						st_r.count[15:8]; // see [R15] see [R20]
				end
				`TC_OFS_CTRL: begin
					st_nxt.rdata = st_r.ctrl & `TC_CTRL_MASK; // see [R7]
				end
				`TC_OFS_FLAG: begin
					st_nxt.rdata = {7'h00, st_r.flag};
				end
				`TC_OFS_ENABLE: begin
					st_nxt.rdata = {7'h00, st_r.irq_en};
				end
				default: begin
					// Unmapped reads as zero
					st_nxt.rdata = 8'h00;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// State register

	// Constants only under reset
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_r       <= '0;
			st_r.ctrl  <= `TC_CTRL_RST; // see [R19]
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////
	// Outputs

	assign rd_data   = st_r.rdata;
	assign adc_start = st_r.adc_go;
	// Request only when enabled
	assign irq_req   = st_r.flag && st_r.irq_en; // see [R10]
	// Oscillator forces both pins to input
	assign pin_oe    = osc_on ? 2'b00 : ~port_direction_reg; // see [R6]
	// Pin reads are zero under the oscillator
	assign port_read = osc_on ? 2'b00 : st_r.s2; // see [R6]

	////////////////////////////////////////////////////////////////
	// Checks

	hold_when_off_a: assert property ( // see [R1]
		@(posedge clk) disable iff (sys_rst)
		(!run && !bus.wr && !trig) |=> $stable(st_r.count))
		else $error("count moved while stopped");

	divide_end_a: assert property ( // see [R2]
		@(posedge clk) disable iff (sys_rst)
		(run && ev && div_sel == 2'h3 && !bus.wr && !trig &&
		st_r.pre != 3'h7) |=> $stable(st_r.count))
		else $error("divide by eight stepped early");

	bit6_zero_a: assert property ( // see [R7]
		@(posedge clk) disable iff (sys_rst)
		(bus.rd && bus.addr == `TC_OFS_CTRL) |=> !rd_data[6])
		else $error("unused control bit read as one");

	timer_step_a: assert property ( // see [R8]
		@(posedge clk) disable iff (sys_rst)
		(run && !ext_src && div_sel == 2'h0 && tick && !bus.wr &&
		!trig) |=> st_r.count == $past(st_r.count) + 16'h0001)
		else $error("timer did not step on tick");

	wrap_flag_a: assert property ( // see [R9] see [R10]
		@(posedge clk) disable iff (sys_rst)
		(step && st_r.count == `TC_COUNT_TOP && !bus.wr && !trig)
		|=> (st_r.count == 16'h0000) && st_r.flag)
		else $error("wrap did not set flag");

	trig_reset_a: assert property ( // see [R11] see [R12]
		@(posedge clk) disable iff (sys_rst)
		(trig && !bus.wr && !st_r.flag) |=>
		(st_r.count == 16'h0000) && !st_r.flag &&
		(adc_start == $past(adc_enable)))
		else $error("trigger reset wrong");

	write_wins_a: assert property ( // see [R14]
		@(posedge clk) disable iff (sys_rst)
		(trig && wr_low) |=> st_r.count[7:0] == $past(bus.wdata))
		else $error("trigger beat a write");

	read_latch_a: assert property ( // see [R16]
		@(posedge clk) disable iff (sys_rst)
		(wide && rd_low) |=> st_r.hbuf == $past(st_r.count[15:8]))
		else $error("low read missed high copy");

	wide_write_a: assert property ( // see [R17]
		@(posedge clk) disable iff (sys_rst)
		(wide && wr_low) |=> (st_r.count ==
		{$past(st_r.hbuf), $past(bus.wdata)}) && st_r.pre == 3'h0)
		else $error("wide write not whole");

	high_keeps_pre_a: assert property ( // see [R18]
		@(posedge clk) disable iff (sys_rst)
		(wr_high && !(run && ev) && !trig) |=> $stable(st_r.pre))
		else $error("high write touched prescaler");

	osc_pins_a: assert property ( // see [R6]
		@(posedge clk) disable iff (sys_rst)
		osc_on |-> (pin_oe == 2'b00) && (port_read == 2'b00))
		else $error("oscillator pins not inputs");

	sync_wait_a: assert property ( // see [R4]
		@(posedge clk) disable iff (sys_rst)
		(run && ext_src && !no_sync && !tick && !bus.wr && !trig)
		|=> $stable(st_r.count))
		else $error("synchronized edge counted off tick");

	unsync_step_a: assert property ( // see [R4] see [R8]
		@(posedge clk) disable iff (sys_rst)
		(run && ext_src && no_sync && rise && div_sel == 2'h0 &&
		!bus.wr && !trig) |=> st_r.count == $past(st_r.count) + 16'h0001)
		else $error("unsynchronized edge not counted");

	wide_read_a: assert property ( // see [R15]
		@(posedge clk) disable iff (sys_rst)
		(wide && bus.rd && bus.addr == `TC_OFS_HIGH) |=>
		rd_data == $past(st_r.hbuf))
		else $error("wide high read not from buffer");

	narrow_read_a: assert property ( // see [R20]
		@(posedge clk) disable iff (sys_rst)
		(!wide && bus.rd && bus.addr == `TC_OFS_HIGH) |=>
		rd_data == $past(st_r.count[15:8]))
		else $error("narrow high read not live");

	read_idle_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		!bus.rd |=> rd_data == 8'h00)
		else $error("read data outside its cycle");

	adc_quiet_a: assert property ( // see [R11]
		@(posedge clk) disable iff (sys_rst)
		!trig |=> !adc_start)
		else $error("conversion start without trigger");

endmodule : timer_counter

`default_nettype wire

// ===== bench/sixteen_bit_timer_counter_bench.sv
// Self-checking bench for the sixteen-bit timer/counter
`timescale 1ns/10ps
`default_nettype none
`include "timer_counter_cfg.svh"

module sixteen_bit_timer_counter_bench;

	logic                        clk;       // Core clock
	logic                        sys_rst;   // Async reset
	timer_counter_pkg::reg_bus_t bus;       // Register port
	logic [7:0]                  rd_data;   // Read data
	logic [1:0]                  pins;      // Osc, count pin
	logic [1:0]                  dir;       // Port direction
	logic [1:0]                  pin_oe;    // Pin enables
	logic [1:0]                  port_read; // Pin view
	logic [3:0]                  cmp_mode;  // Compare mode
	logic                        match;     // Compare pulse
	logic                        adc_en;    // Converter on
	logic                        adc_start; // Conversion start
	logic                        irq_req;   // Interrupt request
	int                          fail_count;
	int                          total_checks;
	int                          cyc;       // Timeout counter
	logic [7:0]                  a;         // Read scratch
	logic [7:0]                  b;         // Read scratch

	timer_counter dut (.clk(clk), .sys_rst(sys_rst), .bus(bus),
		.rd_data(rd_data), .ext_count_pin(pins[0]),
		.osc_in_pin(pins[1]), .port_direction_reg(dir), .pin_oe(pin_oe),
		.port_read(port_read), .compare_mode_field(cmp_mode),
		.compare_match(match), .adc_enable(adc_en),
		.adc_start(adc_start), .irq_req(irq_req));

	////////////////////////////////////////////////////////////////////
	// Clock and hang guard
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count = fail_count + 1;
			print_verdict();
		end
	end

	////////////////////////////////////////////////////////////////////
	// Shared tasks
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks = total_checks + 1;
		if (got !== exp) begin
			fail_count = fail_count + 1;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [2:0] ad, input logic [7:0] d);
		@(posedge clk);
		bus <= '{addr: ad, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [2:0] ad, output logic [7:0] d);
		@(posedge clk);
		bus <= '{addr: ad, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus.rd <= 1'b0;
		#1 d = rd_data;
	endtask : rd

	// Counts over an exact span of clocks, phase independent
	task automatic rate(input logic [7:0] c, input int n, input int e);
		wr(`TC_OFS_CTRL, c);
		rd(`TC_OFS_LOW, a);
		repeat (n - 2) @(posedge clk);
		rd(`TC_OFS_LOW, b);
		chk(16'(8'(b - a)), 16'(e));
	endtask : rate

	// Five rising edges on one source pin
	task automatic edges(input logic [7:0] c, input int i);
		wr(`TC_OFS_CTRL, c);
		repeat (12) @(posedge clk);
		rd(`TC_OFS_LOW, a);
		repeat (5) begin
			@(posedge clk);
			pins[i] <= 1'b1;
			repeat (6) @(posedge clk);
			pins[i] <= 1'b0;
			repeat (5) @(posedge clk);
		end
		repeat (12) @(posedge clk);
		rd(`TC_OFS_LOW, b);
		chk(16'(8'(b - a)), 16'h0005);
	endtask : edges

	// Trigger pulse, optionally beside a low byte write of 56
	task automatic trig(input logic [3:0] m, input logic w,
		input logic [7:0] e);
		@(posedge clk);
		cmp_mode <= m;
		match    <= 1'b1;
		if (w) begin
			bus <= '{addr: `TC_OFS_LOW, wdata: 8'h56, wr: 1'b1, rd: 1'b0};
		end
		@(posedge clk);
		match  <= 1'b0;
		bus.wr <= 1'b0;
		#1 if (!w) begin
			chk(16'(adc_start),
				16'(adc_en && m == `TC_SPECIAL_EVT));
		end
		rd(`TC_OFS_LOW, a);
		chk(16'(a), 16'(e));
	endtask : trig

	task automatic print_verdict;
		if (fail_count == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : print_verdict

	////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		sys_rst = 1'b1;
		bus = '0;
		pins = 2'b00;
		dir = 2'b01;
		cmp_mode = 4'h0;
		match = 1'b0;
		adc_en = 1'b1;
		fail_count = 0;
		total_checks = 0;
		cyc = 0;
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		// Reset value, unmapped index, bit six
		rd(`TC_OFS_CTRL, a);
		chk(16'(a), 16'h0000);
		rd(3'h7, a);
		chk(16'(a), 16'h0000);
		wr(`TC_OFS_CTRL, 8'hFE);
		rd(`TC_OFS_CTRL, a);
		chk(16'(a), 16'h00BE);
		// Hold, every divide code, sync bit ignored internally
		rate(8'h00, 40, 0);
		rate(8'h01, 40, 10);
		rate(8'h11, 80, 10);
		rate(8'h21, 160, 10);
		rate(8'h31, 320, 10);
		rate(8'h05, 40, 10);
		// Wrap, sticky flag, enable gating
		wr(`TC_OFS_CTRL, 8'h00);
		wr(`TC_OFS_HIGH, 8'hFF);
		wr(`TC_OFS_LOW, 8'hFE);
		wr(`TC_OFS_CTRL, 8'h01);
		repeat (20) @(posedge clk);
		wr(`TC_OFS_CTRL, 8'h00);
		rd(`TC_OFS_HIGH, a);
		chk(16'(a), 16'h0000);
		rd(`TC_OFS_FLAG, a);
		chk(16'(a), 16'h0001);
		chk(16'(irq_req), 16'h0000);
		wr(`TC_OFS_ENABLE, 8'h01);
		@(posedge clk);
		chk(16'(irq_req), 16'h0001);
		wr(`TC_OFS_FLAG, 8'h00);
		@(posedge clk);
		chk(16'(irq_req), 16'h0000);
		// Trigger reset, wrong mode, flag left clear; timer mode only
		wr(`TC_OFS_HIGH, 8'h12);
		wr(`TC_OFS_LOW, 8'h34);
		trig(4'hA, 1'b0, 8'h34);
		trig(`TC_SPECIAL_EVT, 1'b0, 8'h00);
		rd(`TC_OFS_HIGH, a);
		chk(16'(a), 16'h0000);
		rd(`TC_OFS_FLAG, a);
		chk(16'(a), 16'h0000);
		// Converter off: reset still, no conversion start; then a low byte write beats the trigger
		@(posedge clk);
		adc_en <= 1'b0;
		trig(`TC_SPECIAL_EVT, 1'b0, 8'h00);
		@(posedge clk);
		adc_en <= 1'b1;
		trig(`TC_SPECIAL_EVT, 1'b1, 8'h56);
		// Wide access through the high byte buffer
		wr(`TC_OFS_CTRL, 8'h80);
		wr(`TC_OFS_HIGH, 8'hAB);
		wr(`TC_OFS_LOW, 8'hCD);
		wr(`TC_OFS_HIGH, 8'h12);
		rd(`TC_OFS_HIGH, a);
		chk(16'(a), 16'h0012);
		rd(`TC_OFS_LOW, a);
		rd(`TC_OFS_HIGH, b);
		chk({b, a}, 16'hABCD);
		// Narrow access reaches the live high byte
		wr(`TC_OFS_CTRL, 8'h00);
		wr(`TC_OFS_HIGH, 8'h77);
		rd(`TC_OFS_HIGH, a);
		rd(`TC_OFS_LOW, b);
		chk({a, b}, 16'h77CD);
		// Divide by eight: low write clears prescaler, high write not
		wr(`TC_OFS_CTRL, 8'h31);
		repeat (50) @(posedge clk);
		wr(`TC_OFS_LOW, 8'h00);
		repeat (14) @(posedge clk);
		wr(`TC_OFS_HIGH, 8'h77);
		repeat (11) @(posedge clk);
		rd(`TC_OFS_LOW, a);
		chk(16'(a), 16'h0000);
		repeat (2) @(posedge clk);
		rd(`TC_OFS_LOW, a);
		chk(16'(a), 16'h0001);
		wr(`TC_OFS_CTRL, 8'h00);
		// Oscillator source and pin view
		edges(8'h0B, 1);
		pins <= 2'b11;
		repeat (4) @(posedge clk);
		chk(16'(pin_oe), 16'h0000);
		chk(16'(port_read), 16'h0000);
		pins <= 2'b00;
		edges(8'h03, 0);
		pins <= 2'b01;
		repeat (4) @(posedge clk);
		chk(16'(pin_oe), {14'h0000, ~dir});
		chk(16'(port_read), 16'h0001);
		pins <= 2'b00;
		edges(8'h07, 0);
		print_verdict();
	end

endmodule : sixteen_bit_timer_counter_bench
`default_nettype wire
